// ==== hdl/arcp_regs.sv ====
// result, compare value and analog pin release register block
// Functional notes
// - 12-bit: high nibble in high, byte in low
// - results update each completion unless compare fails
// - high read locks results until low read
// - conversion during pending lock is discarded
// - 8-bit mode has no read interlock
// - fifo mode completes when result fifo reaches depth
// - fifo results read back in channel order
// - mode change invalidates held results
// - high bits 7-4 of result/compare read zero
// - low result register holds eight low bits
// - 12-bit compare checks high nibble too
// - compare low byte against low result bits
// - first release register covers channels 0-7
// - second release register covers channels 8-11
// - release bit one disables port control
// - released pin: no drive, input zero, no pullup
// - compare active only while its enable set
// - depth field zero disables, else depth 2-8
// - blocked transfer leaves complete flag, drops result
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
module arcp_regs #(
  parameter int NCH = arcp_pkg::ARCP_CHANNELS  // analog channels with a pin
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  // register port
  input  wire arcp_pkg::arcp_bus_t   req_i,
  output logic [7:0]                 rdata_o,
  // analog conversion engine
  input  wire arcp_pkg::arcp_conv_t  conv_i,
  output logic                       conv_complete_o,
  output logic                       conv_blocked_o,
  output logic [2:0]                 fifo_depth_sel_o,
  // port logic and pins
  input  wire logic [NCH-1:0]        port_oe_i,
  input  wire logic [NCH-1:0]        port_pu_i,
  input  wire logic [NCH-1:0]        pin_in_i,
  output logic [NCH-1:0]             pin_oe_o,
  output logic [NCH-1:0]             pin_pu_o,
  output logic [NCH-1:0]             port_rd_o,
  output logic [NCH-1:0]             pin_release_o
);
  import arcp_pkg::*;

  // configuration and data registers
  logic [6:0]       cfg_r;        // mode, compare enable, depth, sense
  logic [11:0]      cv_r;         // compare_field, 12 bits
  logic [7:0]       apc_lo_r;     // pin_release_ch0..pin_release_ch7
  logic [3:0]       apc_hi_r;     // pin_release_ch8..pin_release_ch11
  logic [11:0]      res_r;        // held result, non-fifo mode
  logic             lock_r;       // high read done, low read pending
  // result fifo
  logic [11:0]      mem_r [ARCP_FIFO_DEPTH];
  logic [2:0]       wptr_r;       // next slot to fill
  logic [2:0]       rptr_r;       // oldest entry
  logic [3:0]       cnt_r;        // entries held
  // pin input synchroniser
  logic [NCH-1:0]   pin_s1_r;     // first stage, read by second only
  logic [NCH-1:0]   pin_s2_r;
  logic [NCH-1:0]   pin_s3_r;
  logic [NCH-1:0]   pin_q_r;      // settled pin level
  // decoded strobes and helpers
  arcp_mode_t       mode;
  logic             wide;         // 12 or 10 bit, interlock applies
  logic             cmp_en;
  logic [2:0]       depth;
  logic             fifo_en;
  logic [3:0]       cap;          // fifo level that completes a set
  logic             wr_cfg;
  logic             mode_chg;
  logic             rh_rd;
  logic             rl_rd;
  logic [11:0]      conv_fmt;     // engine result at current width
  logic [11:0]      cv_fmt;       // compare value at current width
  logic             cmp_hit;
  logic             accept;       // completion that may be kept
  logic             take;         // completion that is kept
  logic             push;
  logic             pop;
  logic [11:0]      head;         // value the result pair shows
  logic [NCH-1:0]   rel;          // pin release vector

  // keep only the bits that the current width produces
  function automatic logic [11:0] arcp_fit(arcp_mode_t m, logic [11:0] v);
    logic [11:0] r;
    r = 12'h000;
    unique case (m)
      ARCP_M12: r = v;
      ARCP_M10: r = {2'h0, v[9:0]};
      ARCP_M8:  r = {4'h0, v[7:0]};
      default:  r = {4'h0, v[7:0]};
    endcase
    return r;
  endfunction

  // field decode
  assign mode     = arcp_mode_t'(cfg_r[ARCP_CFG_MODE_LSB +: 2]);
  // illegal code 2'b11 reads as 8-bit, so it gets no interlock either
  assign wide     = (mode == ARCP_M12) || (mode == ARCP_M10);
  assign cmp_en   = cfg_r[ARCP_CFG_CMP_EN];
  assign depth    = cfg_r[ARCP_CFG_DEP_LSB +: 3];
  assign fifo_en  = (depth != 3'h0);
  assign cap      = {1'b0, depth} + 4'h1;
  assign wr_cfg   = req_i.wr && (req_i.addr == ARCP_OFF_CFG);
  assign mode_chg = wr_cfg &&
                    (req_i.wdata[ARCP_CFG_MODE_LSB +: 2] != mode);
  assign rh_rd    = req_i.rd && (req_i.addr == ARCP_OFF_RH);
  assign rl_rd    = req_i.rd && (req_i.addr == ARCP_OFF_RL);

  // compare: both sides trimmed to the width, so 12-bit checks the
  // high nibble as well as the low byte
  assign conv_fmt = arcp_fit(mode, conv_i.data);
  assign cv_fmt   = arcp_fit(mode, cv_r);
  assign cmp_hit  = cfg_r[ARCP_CFG_CMP_GE] ?
                    (conv_fmt >= cv_fmt) :
                    (conv_fmt <  cv_fmt);

  // a failed compare keeps the old contents only while enabled
  assign accept = conv_i.done && !(cmp_en && !cmp_hit);
  // a pending interlock swallows the completion
  assign take   = accept && !lock_r;
  // fifo fills up to its set depth; beyond that results are lost
  assign push   = take && fifo_en && (cnt_r < cap);
  assign pop    = rl_rd && fifo_en && (cnt_r != 4'h0);
  assign head   = fifo_en ? mem_r[rptr_r] : res_r;

  // release vector, reserved high bits never reach it
  assign rel = NCH'({apc_hi_r, apc_lo_r});

  // configuration register; bit 7 is not stored
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_r <= ARCP_CFG_RST;
    end else if (wr_cfg) begin
      cfg_r <= req_i.wdata[6:0];
    end
  end

  // compare value; the upper nibble of the high byte is dropped
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cv_r <= ARCP_CV_RST;
    end else if (req_i.wr && (req_i.addr == ARCP_OFF_CVH)) begin
      cv_r[11:8] <= req_i.wdata[3:0];
    end else if (req_i.wr && (req_i.addr == ARCP_OFF_CVL)) begin
      cv_r[7:0] <= req_i.wdata;
    end
  end

  // pin release registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      apc_lo_r <= ARCP_APC_RST;
      apc_hi_r <= ARCP_APC2_RST;
    end else if (req_i.wr && (req_i.addr == ARCP_OFF_APC_LO)) begin
      apc_lo_r <= req_i.wdata;
    end else if (req_i.wr && (req_i.addr == ARCP_OFF_APC_HI)) begin
      apc_hi_r <= req_i.wdata[3:0];
    end
  end

  // read interlock; a mode change also drops it
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lock_r <= 1'b0;
    end else if (mode_chg || !wide) begin
      lock_r <= 1'b0;
    end else if (rh_rd) begin
      lock_r <= 1'b1;
    end else if (rl_rd) begin
      lock_r <= 1'b0;
    end
  end

  // held result outside fifo mode
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      res_r <= ARCP_RES_RST;
    end else if (mode_chg) begin
      res_r <= ARCP_RES_RST;
    end else if (take && !fifo_en) begin
      res_r <= conv_fmt;
    end
  end

  // fifo storage; no reset needed, pointers say what is valid
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wptr_r] <= conv_fmt;
    end
  end

  // fifo pointers; flushed on mode change or depth change
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wptr_r <= 3'h0;
      rptr_r <= 3'h0;
      cnt_r  <= 4'h0;
    end else if (wr_cfg && (mode_chg ||
                 req_i.wdata[ARCP_CFG_DEP_LSB +: 3] != depth)) begin
      wptr_r <= 3'h0;
      rptr_r <= 3'h0;
      cnt_r  <= 4'h0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 3'h1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 3'h1;
      end
      unique case ({push, pop})
        2'b10:   cnt_r <= cnt_r + 4'h1;
        2'b01:   cnt_r <= cnt_r - 4'h1;
        default: cnt_r <= cnt_r;
      endcase
    end
  end

  // complete flag: set wins over the low-byte read that clears it
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conv_complete_o <= 1'b0;
    end else if (take && !fifo_en) begin
      conv_complete_o <= 1'b1;
    end else if (push && (cnt_r + 4'h1 == cap)) begin
      conv_complete_o <= 1'b1;
    end else if (mode_chg || rl_rd) begin
      conv_complete_o <= 1'b0;
    end
  end

  // blocked pulse tells the engine to restart; flag is left alone
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conv_blocked_o <= 1'b0;
    end else begin
      conv_blocked_o <= accept && lock_r;
    end
  end

  // depth select out to the channel fifo logic
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fifo_depth_sel_o <= 3'h0;
    end else begin
      fifo_depth_sel_o <= depth;
    end
  end

  // read data, valid the cycle after the strobe only
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= 8'h00;
    end else if (!req_i.rd) begin
      rdata_o <= 8'h00;
    end else begin
      unique case (req_i.addr)
        ARCP_OFF_RH:     rdata_o <= {4'h0, head[11:8]};
        ARCP_OFF_RL:     rdata_o <= head[7:0];
        ARCP_OFF_CVH:    rdata_o <= {4'h0, cv_r[11:8]};
        ARCP_OFF_CVL:    rdata_o <= cv_r[7:0];
        ARCP_OFF_CFG:    rdata_o <= {1'b0, cfg_r};
        ARCP_OFF_APC_LO: rdata_o <= apc_lo_r;
        ARCP_OFF_APC_HI: rdata_o <= {4'h0, apc_hi_r};
        default:         rdata_o <= 8'h00;
      endcase
    end
  end

  // pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_q_r  <= '0;
    end else begin
      pin_s1_r <= pin_in_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_q_r  <= (pin_s2_r & pin_s3_r) |
                  (pin_q_r & (pin_s2_r ^ pin_s3_r));
    end
  end

  // pin gating; one in a release bit takes the pin off the port
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_oe_o      <= '0;
      pin_pu_o      <= '0;
      port_rd_o     <= '0;
      pin_release_o <= '0;
    end else begin
      pin_oe_o      <= port_oe_i & ~rel;
      pin_pu_o      <= port_pu_i & ~rel;
      port_rd_o     <= pin_q_r & ~rel;
      pin_release_o <= rel;
    end
  end

  // checks on the behaviour above
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence rh_read_s;
    rh_rd && wide;
  endsequence

  sequence conv_kept_s;
    take && !fifo_en && !mode_chg;
  endsequence

  // a completion just after a high read is turned away
  rh_then_conv_a: assert property (
    rh_read_s ##1 accept |=> conv_blocked_o && $stable(res_r))
    else $error("completion after high read not blocked");

  // the held result may not move under a pending lock
  lock_drop_a: assert property (
    lock_r && accept && !fifo_en && !mode_chg |=> $stable(res_r))
    else $error("result changed while interlock pending");

  // a dropped completion leaves the flag as it was
  flag_hold_a: assert property (
    accept && lock_r && !rl_rd && !mode_chg |=> $stable(conv_complete_o))
    else $error("blocked completion touched the flag");

  no_lock8_a: assert property (
    !wide |-> !lock_r)
    else $error("interlock active in 8-bit mode");

  // a kept completion lands one cycle later, trimmed to width
  res_update_a: assert property (
    conv_kept_s |=> res_r == $past(conv_fmt))
    else $error("kept result not stored");

  cmp_keep_a: assert property (
    conv_i.done && cmp_en && !cmp_hit && !mode_chg |=> $stable(res_r))
    else $error("failed compare overwrote result");

  hi_zero_a: assert property (
    req_i.rd && (req_i.addr == ARCP_OFF_RH ||
                 req_i.addr == ARCP_OFF_CVH) |=> rdata_o[7:4] == 4'h0)
    else $error("reserved high bits read nonzero");

  split12_a: assert property (
    rh_rd && mode == ARCP_M12 && !fifo_en
      |=> rdata_o[3:0] == $past(res_r[11:8]))
    else $error("high nibble of result misplaced");

  // the push that brings the fifo to its set level raises the flag
  fifo_done_a: assert property (
    push && !wr_cfg && (cnt_r + 4'h1 == cap) |=> conv_complete_o)
    else $error("fifo full but no completion");

  fifo_order_a: assert property (
    pop && !wr_cfg |=> rptr_r == 3'($past(rptr_r) + 3'h1))
    else $error("fifo read out of order");

  // a new width makes held data meaningless, fifo included
  mode_inval_a: assert property (
    mode_chg |=> res_r == ARCP_RES_RST && cnt_r == 4'h0 && !lock_r)
    else $error("mode change kept old results");

  // gating flops add one cycle, hence the past release vector
  pin_free_a: assert property (
    ##1 ((pin_oe_o | pin_pu_o | port_rd_o) & $past(rel)) == '0)
    else $error("released pin still under port control");

endmodule

// ==== hdl/arcp_pkg.sv ====
// package for the converter result, compare and pin release registers
package arcp_pkg;

  // register byte offsets on the plain register port
  localparam logic [15:0] ARCP_OFF_RH      = 16'h0003;
  localparam logic [15:0] ARCP_OFF_RL      = 16'h0004;
  localparam logic [15:0] ARCP_OFF_CVH     = 16'h0006;
  localparam logic [15:0] ARCP_OFF_CVL     = 16'h0007;
  localparam logic [15:0] ARCP_OFF_CFG     = 16'h0020;
  localparam logic [15:0] ARCP_OFF_APC_LO  = 16'h309c;
  localparam logic [15:0] ARCP_OFF_APC_HI  = 16'h309d;

  // configuration register field positions
  localparam int ARCP_CFG_MODE_LSB = 0;
  localparam int ARCP_CFG_CMP_EN   = 2;
  localparam int ARCP_CFG_DEP_LSB  = 3;
  localparam int ARCP_CFG_CMP_GE   = 6;

  // values after reset
  localparam logic [6:0]  ARCP_CFG_RST  = 7'h00;
  localparam logic [11:0] ARCP_RES_RST  = 12'h000;
  localparam logic [11:0] ARCP_CV_RST   = 12'h000;
  localparam logic [7:0]  ARCP_APC_RST  = 8'h00;
  localparam logic [3:0]  ARCP_APC2_RST = 4'h0;

  // result fifo depth and analog channel count
  localparam int ARCP_FIFO_DEPTH = 8;
  localparam int ARCP_CHANNELS   = 12;

  // resolution modes; code 2'b11 is illegal and behaves as 8-bit
  typedef enum logic [1:0] {
    ARCP_M8  = 2'b00,
    ARCP_M12 = 2'b01,
    ARCP_M10 = 2'b10
  } arcp_mode_t;

  // one register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } arcp_bus_t;

  // one finished conversion from the analog engine
  typedef struct packed {
    logic        done;
    logic [11:0] data;
  } arcp_conv_t;

endpackage

// ==== sim/arcp_conv_model.sv ====
// behavioural analog engine that hands finished conversions to the block
`timescale 1ns/10ps
module arcp_conv_model
  import arcp_pkg::*;
(
  // clock and reset
  input  wire logic            clk_i,
  input  wire logic            sys_rst_i,
  // bench command
  input  wire logic            fire_i,
  input  wire logic [11:0]     val_i,
  // conversion towards the block
  output arcp_pkg::arcp_conv_t conv_o
);
  logic [11:0] last_r;  // last value handed over

  // remember the last value so idle data can be scrambled
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      last_r <= 12'h000;
    end else if (fire_i) begin
      last_r <= val_i;
    end
  end

  // data means nothing without done; idle shows the inverse so that
  // the block cannot lean on a stale value
  assign conv_o.done = fire_i;
  assign conv_o.data = fire_i ? val_i : ~last_r;
endmodule

// ==== sim/arcp_regs_tb.sv ====
// self-checking bench for the result, compare and pin release registers
`timescale 1ns/10ps
module arcp_regs_tb;
  import arcp_pkg::*;
  logic        clk_i;      // bus clock
  logic        sys_rst_i;  // async reset
  arcp_bus_t   req;        // register port request
  logic [7:0]  rdata;      // read data
  arcp_conv_t  conv;       // engine to block
  logic        fire;       // engine command
  logic [11:0] val;        // engine value
  logic        done_flag;  // conversion complete
  logic        blocked;    // dropped by interlock
  logic        blk;        // blocked seen after a conversion
  logic [2:0]  dep_sel;    // depth field copy
  logic [11:0] port_oe, port_pu, pin_in, pin_oe, pin_pu, port_rd, rel;
  int          miscompares;
  int          checks;
  int          cycles;
  logic [35:0] rows [4];   // cfg, value, expected high, expected low

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  arcp_regs u_arcp_regs (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req), .rdata_o(rdata),
    .conv_i(conv), .conv_complete_o(done_flag), .conv_blocked_o(blocked),
    .fifo_depth_sel_o(dep_sel), .port_oe_i(port_oe), .port_pu_i(port_pu),
    .pin_in_i(pin_in), .pin_oe_o(pin_oe), .pin_pu_o(pin_pu),
    .port_rd_o(port_rd), .pin_release_o(rel));

  arcp_conv_model u_arcp_conv_model (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .fire_i(fire), .val_i(val),
    .conv_o(conv));

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one-cycle write strobe, then an idle cycle
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req <= '0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req <= '0;
    #1;
    chk({4'h0, rdata}, {4'h0, exp});
  endtask

  // one done pulse; blocked is registered at the sampling edge
  task automatic convert(input logic [11:0] v);
    @(posedge clk_i);
    fire <= 1'b1;
    val  <= v;
    @(posedge clk_i);
    fire <= 1'b0;
    #1;
    blk = blocked;
  endtask

  task automatic note(input string s);
    $display("end of test: %s", s);
  endtask

  // cut a hang short; no test needs near this many cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    sys_rst_i = 1'b1;
    req = '0;
    fire = 1'b0;
    val = 12'h000;
    port_oe = 12'hf0f;
    port_pu = 12'h0ff;
    pin_in = 12'hfff;
    miscompares = 0;
    checks = 0;
    cycles = 0;
    rows[0] = {8'h01, 12'habc, 8'h0a, 8'hbc};
    rows[1] = {8'h02, 12'hfff, 8'h03, 8'hff};
    rows[2] = {8'h00, 12'hfff, 8'h00, 8'hff};
    rows[3] = {8'h03, 12'h1a5, 8'h00, 8'ha5};
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // reset values and pins with nothing released
    repeat (6) @(posedge clk_i);
    chk(pin_oe, 12'hf0f);
    chk(port_rd, 12'hfff);
    rd_chk(ARCP_OFF_RH, 8'h00);
    rd_chk(ARCP_OFF_RL, 8'h00);
    rd_chk(ARCP_OFF_CVH, 8'h00);
    rd_chk(ARCP_OFF_APC_LO, 8'h00);
    rd_chk(ARCP_OFF_APC_HI, 8'h00);
    rd_chk(16'h0005, 8'h00);
    note("reset");
    // ordinary conversions in every mode code
    for (int i = 0; i < 4; i++) begin
      bus_wr(ARCP_OFF_CFG, rows[i][35:28]);
      convert(rows[i][27:16]);
      chk(12'(done_flag), 12'h001);
      rd_chk(ARCP_OFF_RH, rows[i][15:8]);
      rd_chk(ARCP_OFF_RL, rows[i][7:0]);
      chk(12'(done_flag), 12'h000);
    end
    note("modes");
    // interlock in 12-bit, none in 8-bit
    bus_wr(ARCP_OFF_CFG, 8'h01);
    convert(12'h123);
    rd_chk(ARCP_OFF_RH, 8'h01);
    convert(12'h456);
    chk(12'(blk), 12'h001);
    rd_chk(ARCP_OFF_RL, 8'h23);
    convert(12'h789);
    chk(12'(blk), 12'h000);
    rd_chk(ARCP_OFF_RH, 8'h07);
    rd_chk(ARCP_OFF_RL, 8'h89);
    bus_wr(ARCP_OFF_CFG, 8'h00);
    convert(12'h0aa);
    rd_chk(ARCP_OFF_RH, 8'h00);
    convert(12'h055);
    chk(12'(blk), 12'h000);
    rd_chk(ARCP_OFF_RL, 8'h55);
    note("interlock");
    // compare keeps results at or above, then below, the compare value, then is switched off
    bus_wr(ARCP_OFF_CFG, 8'h01);
    bus_wr(ARCP_OFF_CVH, 8'hf8);
    bus_wr(ARCP_OFF_CVL, 8'h05);
    rd_chk(ARCP_OFF_CVH, 8'h08);
    rd_chk(ARCP_OFF_CVL, 8'h05);
    bus_wr(ARCP_OFF_CFG, 8'h45);
    convert(12'h300);
    chk(12'(done_flag), 12'h000);
    convert(12'h804);
    chk(12'(done_flag), 12'h000);
    rd_chk(ARCP_OFF_RL, 8'h00);
    convert(12'h805);
    chk(12'(done_flag), 12'h001);
    rd_chk(ARCP_OFF_RH, 8'h08);
    rd_chk(ARCP_OFF_RL, 8'h05);
    bus_wr(ARCP_OFF_CFG, 8'h05);
    convert(12'h900);
    chk(12'(done_flag), 12'h000);
    convert(12'h804);
    chk(12'(done_flag), 12'h001);
    rd_chk(ARCP_OFF_RL, 8'h04);
    bus_wr(ARCP_OFF_CFG, 8'h01);
    convert(12'h300);
    chk(12'(done_flag), 12'h001);
    rd_chk(ARCP_OFF_RH, 8'h03);
    rd_chk(ARCP_OFF_RL, 8'h00);
    note("compare");
    // three-entry fifo fills, then reads back in order
    bus_wr(ARCP_OFF_CFG, 8'h11);
    repeat (2) @(negedge clk_i);
    chk(12'(dep_sel), 12'h002);
    for (int i = 1; i < 4; i++) begin
      convert(12'(i * 273));
      chk(12'(done_flag), 12'(i == 3));
    end
    for (int i = 1; i < 4; i++) begin
      rd_chk(ARCP_OFF_RH, 8'(i));
      rd_chk(ARCP_OFF_RL, 8'(i * 17));
    end
    bus_wr(ARCP_OFF_CFG, 8'h39);
    repeat (2) @(negedge clk_i);
    chk(12'(dep_sel), 12'h007);
    note("fifo");
    // mode change throws held data away; result bytes ignore writes
    bus_wr(ARCP_OFF_CFG, 8'h01);
    convert(12'habc);
    bus_wr(ARCP_OFF_CFG, 8'h02);
    @(negedge clk_i);
    chk(12'(done_flag), 12'h000);
    bus_wr(ARCP_OFF_RL, 8'hff);
    rd_chk(ARCP_OFF_RL, 8'h00);
    note("mode change");
    // pin release
    bus_wr(ARCP_OFF_APC_LO, 8'h81);
    bus_wr(ARCP_OFF_APC_HI, 8'hf9);
    rd_chk(ARCP_OFF_APC_LO, 8'h81);
    rd_chk(ARCP_OFF_APC_HI, 8'h09);
    repeat (6) @(posedge clk_i);
    chk(rel, 12'h981);
    chk(pin_oe, 12'h60e);
    chk(pin_pu, 12'h07e);
    chk(port_rd, 12'h67e);
    note("pins");
    wrap_up();
  end
endmodule
